// file: csp_pkg.sv
`default_nettype none
package csp_pkg;
	// Register byte addresses on the APB
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_STAT  = 8'h04;
	localparam logic [7:0] ADDR_UPPER = 8'h08;
	localparam logic [7:0] ADDR_LOWER = 8'h0C;
	// Values after reset
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] STAT_RESET = 8'h9C;
	// Status field positions
	localparam int STAT_LEVEL = 6;
	localparam int STAT_OVR   = 5;
	localparam int STAT_TAIL  = 1;
	localparam int STAT_START = 0;
	// Transfer lengths in bits and tail length in half shift clocks
	localparam logic [4:0] BITS_8      = 5'h08;
	localparam logic [4:0] BITS_16     = 5'h10;
	localparam logic [1:0] TAIL_HALVES = 2'h2;
	// Prescaler ratios, indexed by the divide select field
	localparam int DIV_RATIO [0:7] = '{1024, 256, 64, 32, 16, 8, 4, 2};
	localparam int DIV_W = 9;

	typedef enum logic [1:0] {
		MODE_8    = 2'b00,
		MODE_16   = 2'b01,
		MODE_CONT = 2'b10,
		MODE_RSVD = 2'b11
	} mode_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_TAIL  = 2'b11
	} state_t;

	typedef struct packed {
		mode_t      mode;
		logic       tail_mark_enable;
		logic       latch_tail;
		logic       ext_clk;
		logic [2:0] div_sel;
	} ctrl_t;
endpackage
`default_nettype wire

// file: csp_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module csp_prescaler (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Control
	input  wire logic       restart_i,
	input  wire logic [2:0] div_sel_i,
	// Half shift clock enable
	output logic            half_tick_o
);
	logic [csp_pkg::DIV_W-1:0] count;
	logic [csp_pkg::DIV_W-1:0] half_last;

	always_comb begin
		half_last = (csp_pkg::DIV_W)'(csp_pkg::DIV_RATIO[div_sel_i] / 2 - 1);
	end

	// Restart aligns the first edge to a full half period
	always_ff @(posedge clk_i) begin
		if (rst_i || restart_i || count >= half_last) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	assign half_tick_o = !restart_i && (count >= half_last);
endmodule
`default_nettype wire

// file: clocked_serial_shift_port.sv
`timescale 1ns/1ps
`default_nettype none
module clocked_serial_shift_port (
	// Clock and reset
	input  wire logic        SYS_CLK_I,
	input  wire logic        RESET_I,
	// APB slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic [31:0]      PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// Serial pins
	input  wire logic        SCK_I,
	output logic             SCK_O,
	output logic             SCK_OE_N_O,
	input  wire logic        SI_I,
	output logic             SO_O,
	// Transfer done request
	output logic             DONE_IRQ_O
);
	csp_pkg::ctrl_t  ctrl;
	csp_pkg::state_t state;
	logic [7:0] serial_data_upper;
	logic [7:0] serial_data_lower;
	logic       so_level;
	logic       ovr;
	logic       ovr_armed;
	logic       completed;
	logic       sck_reg;
	logic       sck_prev;
	logic [4:0] bit_cnt;
	logic [1:0] tail_cnt;
	logic       half_tick;
	logic       access;
	logic       commit;
	logic       mapped;
	logic       wr_ctrl;
	logic       wr_stat;
	logic       wr_upper;
	logic       wr_lower;
	logic       start_req;
	logic       ext_rise;
	logic       ext_fall;
	logic       shift_rise;
	logic       shift_fall;
	logic       done;
	logic       ovr_set;
	logic [4:0] last_bit;
	logic [7:0] status;
	logic [7:0] next_rdata;

	// Bus decode; answer one cycle into the access phase
	assign access = PSEL_I && PENABLE_I && !PREADY_O;
	assign commit = PSEL_I && PENABLE_I && PREADY_O;
	assign mapped = PADDR_I == csp_pkg::ADDR_CTRL
		|| PADDR_I == csp_pkg::ADDR_STAT
		|| PADDR_I == csp_pkg::ADDR_UPPER
		|| PADDR_I == csp_pkg::ADDR_LOWER;
	assign wr_ctrl  = commit && PWRITE_I && PADDR_I == csp_pkg::ADDR_CTRL;
	assign wr_stat  = commit && PWRITE_I && PADDR_I == csp_pkg::ADDR_STAT;
	assign wr_upper = commit && PWRITE_I && PADDR_I == csp_pkg::ADDR_UPPER;
	assign wr_lower = commit && PWRITE_I && PADDR_I == csp_pkg::ADDR_LOWER;

	// Reserved ones come from the reset pattern
	always_comb begin
		status = csp_pkg::STAT_RESET;
		status[csp_pkg::STAT_LEVEL] = SO_O;
		status[csp_pkg::STAT_OVR]   = ovr;
		status[csp_pkg::STAT_TAIL]  = state == csp_pkg::ST_TAIL;
		status[csp_pkg::STAT_START] = state == csp_pkg::ST_SHIFT;
	end

	always_comb begin
		unique case (PADDR_I)
			csp_pkg::ADDR_CTRL:  next_rdata = ctrl;
			csp_pkg::ADDR_STAT:  next_rdata = status;
			csp_pkg::ADDR_UPPER: next_rdata = serial_data_upper;
			csp_pkg::ADDR_LOWER: next_rdata = serial_data_lower;
			default:             next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O  <= 32'h00000000;
		end else begin
			PREADY_O  <= access;
			PSLVERR_O <= access && !mapped;
			if (access && !PWRITE_I) begin
				PRDATA_O <= {24'h000000, next_rdata};
			end
		end
	end

	// Writing control also aborts a running transfer
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			ctrl <= csp_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= PWDATA_I[7:0];
		end
	end

	csp_prescaler u_prescaler (
		.clk_i       (SYS_CLK_I),
		.rst_i       (RESET_I),
		.restart_i   (start_req),
		.div_sel_i   (ctrl.div_sel),
		.half_tick_o (half_tick)
	);

	// Pin inputs are synchronous, so one register suffices for edges
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			sck_prev <= 1'b1;
		end else begin
			sck_prev <= SCK_I;
		end
	end

	assign ext_rise = ctrl.ext_clk && SCK_I && !sck_prev;
	assign ext_fall = ctrl.ext_clk && !SCK_I && sck_prev;

	always_comb begin
		if (ctrl.ext_clk) begin
			shift_rise = ext_rise && state == csp_pkg::ST_SHIFT;
			shift_fall = ext_fall && state == csp_pkg::ST_SHIFT;
		end else begin
			shift_rise = half_tick && !sck_reg
				&& state == csp_pkg::ST_SHIFT;
			shift_fall = half_tick && sck_reg
				&& state == csp_pkg::ST_SHIFT;
		end
	end

	// Start ignored in continuous and reserved modes
	assign start_req = wr_stat && PWDATA_I[csp_pkg::STAT_START]
		&& state == csp_pkg::ST_IDLE
		&& !ctrl.mode[1];
	assign last_bit = ctrl.mode == csp_pkg::MODE_16 ?
		csp_pkg::BITS_16 - 5'h01 : csp_pkg::BITS_8 - 5'h01;
	assign done = shift_rise && bit_cnt == last_bit;

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			state    <= csp_pkg::ST_IDLE;
			bit_cnt  <= 5'h00;
			tail_cnt <= 2'h0;
		end else if (wr_ctrl) begin
			state <= csp_pkg::ST_IDLE;
		end else begin
			unique case (state)
				csp_pkg::ST_IDLE: begin
					bit_cnt <= 5'h00;
					if (start_req) begin
						state <= csp_pkg::ST_SHIFT;
					end
				end
				csp_pkg::ST_SHIFT: begin
					if (shift_rise) begin
						bit_cnt <= bit_cnt + 5'h01;
					end
					if (done && ctrl.tail_mark_enable
						&& !ctrl.ext_clk) begin
						state    <= csp_pkg::ST_TAIL;
						tail_cnt <= 2'h0;
					end else if (done) begin
						state <= csp_pkg::ST_IDLE;
					end
				end
				csp_pkg::ST_TAIL: begin
					// Tail occupies one shift clock period
					if (half_tick) begin
						tail_cnt <= tail_cnt + 2'h1;
					end
					if (half_tick
						&& tail_cnt == csp_pkg::TAIL_HALVES - 2'h1) begin
						state <= csp_pkg::ST_IDLE;
					end
				end
				default: state <= csp_pkg::ST_IDLE;
			endcase
		end
	end

	// Internal shift clock; high between transfers, free running on every half tick in continuous mode with the internal clock
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			sck_reg <= 1'b1;
		end else if (!ctrl.ext_clk && ctrl.mode == csp_pkg::MODE_CONT) begin
			if (half_tick) begin
				sck_reg <= !sck_reg;
			end
		end else if (shift_fall || shift_rise) begin
			sck_reg <= !sck_reg;
		end else if (state != csp_pkg::ST_SHIFT) begin
			sck_reg <= 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			SCK_OE_N_O <= 1'b1;
		end else begin
			SCK_OE_N_O <= ctrl.ext_clk;
		end
	end

	assign SCK_O = sck_reg;

	// Output level: software write when idle, else the shifted bit
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			so_level <= 1'b0;
		end else if (shift_fall) begin
			so_level <= serial_data_lower[0];
		end else if (wr_stat && state == csp_pkg::ST_IDLE) begin
			so_level <= PWDATA_I[csp_pkg::STAT_LEVEL];
		end
	end

	assign SO_O = so_level;

	// No reset: contents undefined until software writes them
	always_ff @(posedge SYS_CLK_I) begin
		if (shift_rise) begin
			if (ctrl.mode == csp_pkg::MODE_16) begin
				serial_data_upper <= {SI_I, serial_data_upper[7:1]};
				serial_data_lower <= {serial_data_upper[0],
					serial_data_lower[7:1]};
			end else begin
				serial_data_lower <= {SI_I,
					serial_data_lower[7:1]};
			end
		end else begin
			if (wr_upper) begin
				serial_data_upper <= PWDATA_I[7:0];
			end
			if (wr_lower) begin
				serial_data_lower <= PWDATA_I[7:0];
			end
		end
	end

	// Overrun: a set in the clearing cycle wins
	assign ovr_set = ext_rise && completed && state == csp_pkg::ST_IDLE;

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			completed <= 1'b0;
		end else if (start_req || wr_ctrl) begin
			completed <= 1'b0;
		end else if (done) begin
			completed <= 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			ovr       <= 1'b0;
			ovr_armed <= 1'b0;
		end else begin
			if (ovr_set) begin
				ovr <= 1'b1;
			end else if (wr_stat && ovr_armed
				&& !PWDATA_I[csp_pkg::STAT_OVR]) begin
				ovr <= 1'b0;
			end
			if (commit && !PWRITE_I && PADDR_I == csp_pkg::ADDR_STAT
				&& ovr) begin
				ovr_armed <= 1'b1;
			end else if (!ovr || wr_stat) begin
				ovr_armed <= 1'b0;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			DONE_IRQ_O <= 1'b0;
		end else begin
			DONE_IRQ_O <= done;
		end
	end

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RESET_I);

	property p_reset_state;
		@(posedge SYS_CLK_I) disable iff (1'b0)
		RESET_I |=> (!SO_O && !ovr && state == csp_pkg::ST_IDLE);
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("status state wrong after reset");

	property p_fixed_bits;
		(access && !PWRITE_I && PADDR_I == csp_pkg::ADDR_STAT)
		|=> (PRDATA_O[7:0] & 8'h9C) == 8'h9C;
	endproperty
	a_fixed_bits: assert property (p_fixed_bits)
		else $error("reserved status bits not read as one");

	property p_level_read;
		(access && !PWRITE_I && PADDR_I == csp_pkg::ADDR_STAT)
		|=> PRDATA_O[6] == $past(SO_O);
	endproperty
	a_level_read: assert property (p_level_read)
		else $error("level bit does not show output pin");

	property p_start;
		start_req |=> state == csp_pkg::ST_SHIFT ##0 PRDATA_O[31:8] == 0;
	endproperty
	a_start: assert property (p_start)
		else $error("start write did not begin transfer");

	property p_done_clears;
		done && !wr_ctrl |=> state != csp_pkg::ST_SHIFT && DONE_IRQ_O;
	endproperty
	a_done_clears: assert property (p_done_clears)
		else $error("completion did not clear start or raise request");

	property p_ovr_set;
		ovr_set |=> ovr [*2];
	endproperty
	a_ovr_set: assert property (p_ovr_set)
		else $error("overrun flag not set by late clock");

	property p_ovr_one_ignored;
		ovr && wr_stat && PWDATA_I[5] |=> ovr;
	endproperty
	a_ovr_one_ignored: assert property (p_ovr_one_ignored)
		else $error("writing one changed overrun flag");

	property p_so_stable;
		state == csp_pkg::ST_SHIFT && !shift_fall |=> $stable(SO_O);
	endproperty
	a_so_stable: assert property (p_so_stable)
		else $error("output bit moved outside falling edge");

	property p_idle_high;
		state == csp_pkg::ST_IDLE && ctrl.mode != csp_pkg::MODE_CONT
		&& !ctrl.ext_clk ##1 state == csp_pkg::ST_IDLE |-> SCK_O;
	endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("idle shift clock not high");

	property p_tail;
		done && ctrl.tail_mark_enable && !ctrl.ext_clk && !wr_ctrl
		|=> state == csp_pkg::ST_TAIL ##0 status[1];
	endproperty
	a_tail: assert property (p_tail)
		else $error("tail flag not shown after data");

	c_start: cover property (start_req);
	c_done16: cover property (done && ctrl.mode == csp_pkg::MODE_16);
	c_overrun: cover property (ovr_set);
	c_tail: cover property (state == csp_pkg::ST_TAIL);
endmodule
`default_nettype wire

// file: csp_peer.sv
`timescale 1ns/1ps
`default_nettype none
module csp_peer (
	// Clock and link
	input  wire logic        clk_i,
	input  wire logic        sck_i,
	input  wire logic        so_i,
	output logic             si_o,
	output logic             ext_sck_o,
	// Bench control
	input  wire logic        load_i,
	input  wire logic [15:0] tx_i,
	input  wire logic [4:0]  pulses_i,
	output logic [15:0]      rx_o
);
	logic [15:0] tx = 16'h0000;
	logic [15:0] rx = 16'h0000;
	logic [4:0]  falls = 5'h00;
	logic [4:0]  base = 5'h00;
	logic [4:0]  left = 5'h00;
	logic [4:0]  idx;
	logic [1:0]  cnt = 2'h0;
	logic        clk_q = 1'b1;
	logic        so_q = 1'b0;

	assign idx = falls - base;
	// Inverse of bit 0 before the first fall, so early sampling shows
	assign si_o = (idx == 5'h00) ? ~tx[0] : tx[idx - 5'h01];
	assign ext_sck_o = clk_q;
	assign rx_o = rx;

	always @(negedge sck_i) begin
		falls <= falls + 5'h01;
	end
	// Value held just before the rise, in case both change on one edge
	always @(posedge sck_i) begin
		rx <= {so_q, rx[15:1]};
	end
	// Own clock idles high, half period of four system clocks
	always @(posedge clk_i) begin
		so_q <= so_i;
		if (load_i) begin
			tx <= tx_i;
			base <= falls;
			left <= pulses_i;
			cnt <= 2'h0;
		end else if (left != 5'h00) begin
			cnt <= cnt + 2'h1;
			if (cnt == 2'h3) begin
				clk_q <= ~clk_q;
				if (!clk_q) begin
					left <= left - 5'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: test_clocked_serial_shift_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_clocked_serial_shift_port;
	localparam logic [7:0] A_CT = csp_pkg::ADDR_CTRL;
	localparam logic [7:0] A_ST = csp_pkg::ADDR_STAT;
	localparam logic [7:0] A_UP = csp_pkg::ADDR_UPPER;
	localparam logic [7:0] A_LO = csp_pkg::ADDR_LOWER;
	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sck_o;
	logic        sck_oe_n;
	logic        sck_w;
	logic        ext_sck;
	logic        si;
	logic        so;
	logic        done;
	logic        p_load;
	logic [15:0] p_tx;
	logic [4:0]  p_pulses;
	logic [15:0] p_rx;
	logic [15:0] rd;
	logic        slv;
	logic        sck_q;
	int          err_count;
	int          n_compared;
	int          low_cnt;
	int          tog;

	// Unknown enable at time zero falls back to the idle external line
	assign sck_w = (sck_oe_n !== 1'b0) ? ext_sck : sck_o;

	clocked_serial_shift_port u_clocked_serial_shift_port (
		.SYS_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .SCK_I(sck_w), .SCK_O(sck_o),
		.SCK_OE_N_O(sck_oe_n), .SI_I(si), .SO_O(so), .DONE_IRQ_O(done)
	);
	csp_peer u_csp_peer (
		.clk_i(clk), .sck_i(sck_w), .so_i(so), .si_o(si),
		.ext_sck_o(ext_sck), .load_i(p_load), .tx_i(p_tx),
		.pulses_i(p_pulses), .rx_o(p_rx)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (!sck_o && !sck_oe_n) low_cnt++;
		if (sck_o !== sck_q) tog++;
		sck_q <= sck_o;
	end

	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		chk("pready", 16'h0001, {15'h0000, pready});
		rd = {8'h00, prdata[7:0]};
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task pulse_load;
		p_load <= 1'b1;
		@(posedge clk);
		p_load <= 1'b0;
	endtask
	task do_reset;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask
	task wait_done;
		int i;
		i = 0;
		while (done !== 1'b1 && i < 20000) begin
			@(posedge clk);
			i++;
		end
		chk("done", 16'h0001, {15'h0000, done});
		@(posedge clk);
	endtask
	task xfer(input logic [7:0] c, input logic [15:0] w,
			input logic [15:0] t, input logic [7:0] go);
		apb(1'b1, A_CT, c);
		apb(1'b1, A_UP, w[15:8]);
		apb(1'b1, A_LO, w[7:0]);
		p_tx <= t;
		if (!c[3]) pulse_load;
		low_cnt = 0;
		apb(1'b1, A_ST, go);
		apb(1'b0, A_ST, 8'h00);
		chk("busy", 16'h0001, rd & 16'h0003);
		if (c[3]) pulse_load;
		wait_done;
		apb(1'b0, A_ST, 8'h00);
		chk("idle", 16'h0000, rd & 16'h0001);
	endtask

	task t_reset;
		apb(1'b0, A_ST, 8'h00);
		chk("stat", 16'h009C, rd);
		apb(1'b1, A_ST, 8'h40);
		apb(1'b0, A_ST, 8'h00);
		chk("stat", 16'h00DC, rd);
		chk("so", 16'h0001, {15'h0000, so});
		apb(1'b1, A_ST, 8'h00);
		apb(1'b0, A_ST, 8'h00);
		chk("stat", 16'h009C, rd);
		apb(1'b0, 8'h10, 8'h00);
		chk("slverr", 16'h0001, {15'h0000, slv});
	endtask
	task t_div;
		for (int d = 0; d < 8; d++) begin
			xfer(8'(d), {8'h66, 8'hA5 ^ 8'(d)}, {8'h00, 8'h3C ^ 8'(d)}, 8'h01);
			chk("low", 16'(4 * csp_pkg::DIV_RATIO[d]), 16'(low_cnt));
			chk("rx", {8'hA5 ^ 8'(d), 8'h00}, p_rx & 16'hFF00);
			chk("so", 16'h0001, {15'h0000, so});
			chk("sck", 16'h0001, {14'h0000, sck_oe_n, sck_o});
			apb(1'b0, A_LO, 8'h00);
			chk("lower", {8'h00, 8'h3C ^ 8'(d)}, rd);
			apb(1'b0, A_UP, 8'h00);
			chk("upper", 16'h0066, rd);
		end
	endtask
	task t_16;
		xfer(8'h47, 16'h1234, 16'hBEEF, 8'h41);
		chk("rx", 16'h1234, p_rx);
		chk("so", 16'h0000, {15'h0000, so});
		chk("level", 16'h0000, rd & 16'h0040);
		apb(1'b0, A_UP, 8'h00);
		chk("upper", 16'h00BE, rd);
		apb(1'b0, A_LO, 8'h00);
		chk("lower", 16'h00EF, rd);
	endtask
	task t_ext;
		p_pulses <= 5'h08;
		xfer(8'h08, 16'h00C8, 16'h0037, 8'h01);
		chk("rx", 16'hC800, p_rx & 16'hFF00);
		chk("oe_n", 16'h0001, {15'h0000, sck_oe_n});
		chk("ovr", 16'h0000, rd & 16'h0020);
		apb(1'b0, A_LO, 8'h00);
		chk("lower", 16'h0037, rd);
		p_pulses <= 5'h01;
		pulse_load;
		repeat (12) @(posedge clk);
		apb(1'b0, A_ST, 8'h00);
		chk("ovr", 16'h0020, rd & 16'h0020);
		apb(1'b1, A_ST, 8'h20);
		apb(1'b0, A_ST, 8'h00);
		chk("ovr", 16'h0020, rd & 16'h0020);
		apb(1'b1, A_ST, 8'h00);
		apb(1'b0, A_ST, 8'h00);
		chk("ovr", 16'h0000, rd & 16'h0020);
	endtask
	task t_tail;
		p_pulses <= 5'h00;
		xfer(8'h22, 16'h0081, 16'h0000, 8'h01);
		chk("tail", 16'h0002, rd & 16'h0002);
		chk("pins", 16'h0003, {14'h0000, so, sck_o});
		repeat (80) @(posedge clk);
		apb(1'b0, A_ST, 8'h00);
		chk("tail", 16'h0000, rd & 16'h0002);
	endtask
	task t_cont;
		apb(1'b1, A_CT, 8'h87);
		// Counter reset off the rising edge to avoid racing the monitor
		@(negedge clk);
		tog = 0;
		repeat (20) @(negedge clk);
		chk("tog", 16'h0014, 16'(tog));
		@(posedge clk);
		apb(1'b1, A_ST, 8'h01);
		apb(1'b0, A_ST, 8'h00);
		chk("start", 16'h0000, rd & 16'h0001);
		apb(1'b1, A_CT, 8'h00);
	endtask

	initial begin
		{rst, psel, penable, pwrite, p_load} = 5'h10;
		{paddr, pwdata, p_tx, p_pulses} = 61'h0;
		{err_count, n_compared, low_cnt, tog} = 128'h0;
		sck_q = 1'b1;
		do_reset;
		t_reset;
		t_div;
		t_16;
		t_ext;
		t_tail;
		t_cont;
		do_reset;
		t_reset;
		print_verdict;
	end
	initial begin
		#1000000;
		$display("FAIL watchdog expected end seen hang");
		err_count++;
		print_verdict;
	end
endmodule
`default_nettype wire
